// ==== swc_top.sv ====
// sleep entry, wake-up sequencing, power-down and time-out flags
// Functional notes
// [R01] sleep entered only by sleep instruction
// [R02] sleep clears watchdog, power-down; sets time-out
// [R03] pin drive states frozen while asleep
// [R04] watchdog reset never drives master clear pin
// [R05] wake on master clear, watchdog, enabled irqs
// [R06] timer interrupt cannot act during sleep
// [R07] master clear resets; others resume execution
// [R08] power-down set at power-up; watchdog wake clears time-out
// [R09] next address captured while sleep executes
// [R10] enabled source wakes regardless of global enable
// [R11] after irq wake, vector if global enable
// [R12] start-up delay except resistor-cap oscillator mode
// [R13] pending enabled flag turns sleep into no-op
// [R14] irq after sleep: complete sleep, wake at once
// [R15] software checks power-down flag after sleep
// [R16] software places no-op after sleep if needed
// [R17] software clears watchdog before sleep
// [R18] watchdog wake from sleep continues, no reset
// [R19] global enable at bit 7, cleared on reset
// [R20] phase clocks restart after delay, fetch resumes
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module swc_top #(
  parameter int WDT_TICKS = 256
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire swc_pkg::swc_bus_t       bus,
  output var  logic [7:0]              rdata,
  input  wire logic                    master_clear_pin_b,
  output var  logic                    master_clear_oe,
  input  wire logic                    wdt_osc,
  input  wire logic [7:0]              cfg_strap,
  input  wire logic                    sleep_instr,
  input  wire logic                    watchdog_clear_instr,
  input  wire logic [swc_pkg::PC_W-1:0] next_pc,
  input  wire swc_pkg::swc_irq_t       irq_flags,
  input  wire logic [swc_pkg::IO_W-1:0] io_out_in,
  input  wire logic [swc_pkg::IO_W-1:0] io_oe_in,
  output var  logic [swc_pkg::IO_W-1:0] io_out,
  output var  logic [swc_pkg::IO_W-1:0] io_oe,
  output var  logic                    osc_drive_en,
  output var  logic                    core_clk_en,
  output var  logic                    core_reset,
  output var  logic                    fetch_req,
  output var  logic [swc_pkg::PC_W-1:0] fetch_addr,
  output var  logic                    vector_req,
  output var  logic [swc_pkg::PC_W-1:0] vector_addr,
  output var  logic                    wdt_cleared,
  output var  logic                    asleep
);
  swc_pkg::swc_st_t r;
  swc_pkg::swc_st_t n;
  logic rstpin_b;
  logic wdt_tick;
  logic wdt_to;
  logic wdog_en;
  logic wake_en;
  logic nop_pend;
  logic rc_mode;

  swc_sync #(.RST_VAL(1'b1)) u_rstpin_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (master_clear_pin_b),
    .q     (rstpin_b)
  );

  swc_sync #(.RST_VAL(1'b0)) u_wdt_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (wdt_osc),
    .q     (wdt_tick)
  );

  assign wdog_en = r.cfg_ok && r.cfg[swc_pkg::WDOG_EN_BIT];
  assign rc_mode = r.cfg[swc_pkg::FOSC_LSB +: 2] == swc_pkg::OSC_RC;

  swc_wdt #(.BASE_TICKS(WDT_TICKS)) u_wdt (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (wdt_tick),
    .enable   (wdog_en),
    .clr      (r.wdt_clr),
    .use_post (r.option[swc_pkg::PSA_BIT]),
    .ps       (r.option[swc_pkg::PS_LSB +: 3]),
    .timeout  (wdt_to)
  );

  // wake sources need only their own enable, not the global one
  always_comb begin
    wake_en  = (r.irqctl[swc_pkg::EXIE_BIT] && irq_flags.ex) || // R10
               (r.irqctl[swc_pkg::PCIE_BIT] && irq_flags.pc) ||
               (r.irqctl[swc_pkg::EEIE_BIT] && irq_flags.ee);
    // timer flag only counts while phase clocks run
    nop_pend = wake_en ||                                        // R06
               (r.irqctl[swc_pkg::TMIE_BIT] && irq_flags.tm);
  end

  always_comb begin
    n           = r;
    n.fetch_req = 1'b0;
    n.vec_req   = 1'b0;
    n.wdt_clr   = watchdog_clear_instr;
    n.core_rst  = 1'b0;
    n.rstpin_oe = 1'b0;                                          // R04
    n.rdata     = swc_pkg::ZERO_BYTE;
    if (!r.cfg_ok) begin
      n.cfg    = cfg_strap;
      n.cfg_ok = 1'b1;
    end
    if (r.core_clk_en) begin
      n.io_out = io_out_in;                                      // R03
      n.io_oe  = io_oe_in;
    end
    if (bus.wr) begin
      if (bus.addr == swc_pkg::OPTION_ADDR) begin
        n.option = bus.wdata;
      end else if (bus.addr == swc_pkg::IRQCTL_ADDR) begin
        n.irqctl = bus.wdata;
      end
    end
    if (bus.rd) begin
      if (bus.addr == swc_pkg::STATUS_ADDR) begin
        n.rdata[swc_pkg::PWRDN_BIT] = r.pwrdn;
        n.rdata[swc_pkg::TO_BIT] = r.to;
      end else if (bus.addr == swc_pkg::IRQCTL_ADDR) begin
        n.rdata = r.irqctl;
      end else if (bus.addr == swc_pkg::OPTION_ADDR) begin
        n.rdata = r.option;
      end else if (bus.addr == swc_pkg::CONFIG_ADDR) begin
        n.rdata = r.cfg;
      end
    end
    case (r.state)
      swc_pkg::SWC_RUN: begin
        if (wdt_to) begin
          // internal reset only, the pin stays released
          n.core_rst = 1'b1;                                     // R04
          n.to       = 1'b0;
          n.irqctl   = swc_pkg::IRQCTL_RST;                      // R19
          n.option   = swc_pkg::OPTION_RST;
        end else if (sleep_instr && !nop_pend) begin             // R01 R13
          n.wdt_clr     = 1'b1;                                  // R02
          n.pwrdn       = 1'b0;
          n.to          = 1'b1;
          n.osc_en      = 1'b0;
          n.core_clk_en = 1'b0;
          n.wake_pc     = next_pc;                               // R09
          n.state       = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        // flags raised during or after sleep wake at once
        if (wake_en || (wdog_en && wdt_to)) begin                // R05 R14
          n.wake_irq = wake_en;
          if (!wake_en) begin
            n.to = 1'b0;                                         // R08 R18
          end
          n.osc_en  = 1'b1;
          n.ost_cnt = '0;
          n.state   = rc_mode ? swc_pkg::SWC_RESUME              // R12
                              : swc_pkg::SWC_OST;
        end
      end
      swc_pkg::SWC_OST: begin
        n.ost_cnt = r.ost_cnt + 11'h001;
        if (r.ost_cnt == swc_pkg::OST_W'(swc_pkg::OST_CYC - 1)) begin // R12
          n.state = swc_pkg::SWC_RESUME;
        end
      end
      default: begin
        // phase clocks back, fetch from the captured address
        n.core_clk_en = 1'b1;                                    // R20
        n.fetch_req   = 1'b1;
        n.fetch_addr  = r.wake_pc;                               // R09
        n.vec_req     = r.wake_irq && r.irqctl[swc_pkg::GIRQ_EN_BIT]; // R11
        n.state       = swc_pkg::SWC_RUN;
      end
    endcase
    if (!rstpin_b) begin
      // full reset; a sleeping core still waits for the oscillator, except in rc mode
      n.core_rst = 1'b1;                                         // R07
      n.to       = 1'b1;
      n.irqctl   = swc_pkg::IRQCTL_RST;                          // R19
      n.option   = swc_pkg::OPTION_RST;
      n.wake_irq = 1'b0;
      n.wake_pc  = '0;
      n.osc_en   = 1'b1;
      n.wdt_clr  = 1'b1;
      if (!r.core_clk_en) begin
        n.state = (rc_mode || r.state == swc_pkg::SWC_RESUME)
                  ? swc_pkg::SWC_RESUME : swc_pkg::SWC_OST;
        if (r.state != swc_pkg::SWC_OST) begin
          n.ost_cnt = '0;
        end
      end else begin
        n.state     = swc_pkg::SWC_RUN;
        n.fetch_req = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r             <= '0;
      r.state       <= swc_pkg::SWC_RUN;
      r.pwrdn       <= 1'b1;                                     // R08
      r.to          <= 1'b1;
      r.option      <= swc_pkg::OPTION_RST;
      r.irqctl      <= swc_pkg::IRQCTL_RST;                      // R19
      r.core_clk_en <= 1'b1;
      r.osc_en      <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rdata           = r.rdata;
  assign master_clear_oe = r.rstpin_oe;
  assign io_out          = r.io_out;
  assign io_oe           = r.io_oe;
  assign osc_drive_en    = r.osc_en;
  assign core_clk_en     = r.core_clk_en;
  assign core_reset      = r.core_rst;
  assign fetch_req       = r.fetch_req;
  assign fetch_addr      = r.fetch_addr;
  assign vector_req      = r.vec_req;
  assign vector_addr     = swc_pkg::VECTOR_ADDR;
  assign wdt_cleared     = r.wdt_clr;
  assign asleep          = r.state == swc_pkg::SWC_SLEEP;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic take_sleep;
  assign take_sleep = r.state == swc_pkg::SWC_RUN && sleep_instr &&
                      rstpin_b && !wdt_to;

  property p_sleep_only_instr;
    r.state == swc_pkg::SWC_SLEEP && $past(r.state) == swc_pkg::SWC_RUN
      |-> $past(sleep_instr);
  endproperty
  a_sleep_only_instr: assert property (p_sleep_only_instr) // R01
    else $error("sleep entered without sleep instruction");

  property p_sleep_effects;
    take_sleep && !nop_pend |=> !r.pwrdn && r.to && !r.osc_en && r.wdt_clr;
  endproperty
  a_sleep_effects: assert property (p_sleep_effects) // R02
    else $error("sleep entry flags wrong");

  property p_io_hold;
    !r.core_clk_en && $past(!r.core_clk_en) |-> $stable(io_out) &&
      $stable(io_oe);
  endproperty
  a_io_hold: assert property (p_io_hold) // R03
    else $error("pin state changed while asleep");

  property p_rstpin_released;
    r.state == swc_pkg::SWC_RUN && wdt_to |=> !master_clear_oe && core_reset;
  endproperty
  a_rstpin_released: assert property (p_rstpin_released) // R04
    else $error("watchdog reset drove master clear");

  property p_irq_wake;
    r.state == swc_pkg::SWC_SLEEP && wake_en && rstpin_b
      |=> r.state inside {swc_pkg::SWC_OST, swc_pkg::SWC_RESUME} ##0 r.osc_en;
  endproperty
  a_irq_wake: assert property (p_irq_wake) // R05
    else $error("enabled interrupt did not wake");

  property p_wdt_wake;
    r.state == swc_pkg::SWC_SLEEP && wdog_en && wdt_to && !wake_en &&
      rstpin_b |=> !r.to && !r.core_rst ##1 !r.core_rst;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) // R18
    else $error("watchdog wake wrong");

  property p_sleep_nop;
    take_sleep && nop_pend |=> r.state == swc_pkg::SWC_RUN &&
      $stable(r.pwrdn) && $stable(r.to) &&
      r.wdt_clr == $past(watchdog_clear_instr);
  endproperty
  a_sleep_nop: assert property (p_sleep_nop) // R13
    else $error("sleep not a no-op with pending flag");

  property p_ost_len;
    r.state == swc_pkg::SWC_RESUME && $past(r.state) == swc_pkg::SWC_OST
      |-> $past(r.ost_cnt) == swc_pkg::OST_W'(swc_pkg::OST_CYC - 1);
  endproperty
  a_ost_len: assert property (p_ost_len) // R12
    else $error("start-up delay wrong length");

  property p_resume;
    r.state == swc_pkg::SWC_RESUME && rstpin_b |=> core_clk_en &&
      fetch_req && fetch_addr == $past(r.wake_pc) &&
      vector_req == $past(r.wake_irq && r.irqctl[swc_pkg::GIRQ_EN_BIT]);
  endproperty
  a_resume: assert property (p_resume) // R20
    else $error("resume sequence wrong");

  property p_girq_clear;
    !rstpin_b |=> !r.irqctl[swc_pkg::GIRQ_EN_BIT] && core_reset;
  endproperty
  a_girq_clear: assert property (p_girq_clear) // R19
    else $error("global enable survived reset");

  c_sleep: cover property (take_sleep && !nop_pend);
  c_wdt_wake: cover property (r.state == swc_pkg::SWC_SLEEP && wdt_to);
  c_vector: cover property (vector_req);
  c_nop: cover property (take_sleep && nop_pend);
endmodule
`default_nettype wire

// ==== swc_pkg.sv ====
// shared constants, types and state records of the sleep/wake controller
`default_nettype none
package swc_pkg;
  localparam int          ADDR_W      = 14;
  localparam int          PC_W        = 13;
  localparam int          IO_W        = 13;
  localparam logic [13:0] STATUS_ADDR = 14'h0003;
  localparam logic [13:0] IRQCTL_ADDR = 14'h000B;
  localparam logic [13:0] OPTION_ADDR = 14'h0081;
  localparam logic [13:0] CONFIG_ADDR = 14'h2007;
  localparam logic [7:0]  OPTION_RST  = 8'hFF;
  localparam logic [7:0]  IRQCTL_RST  = 8'h00;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  // status bit positions
  localparam int PWRDN_BIT = 3;
  localparam int TO_BIT   = 4;
  // irq control bit positions
  localparam int GIRQ_EN_BIT = 7;
  localparam int EEIE_BIT = 6;
  localparam int TMIE_BIT = 5;
  localparam int EXIE_BIT = 4;
  localparam int PCIE_BIT = 3;
  // option and config bit positions
  localparam int PSA_BIT  = 3;
  localparam int PS_LSB   = 0;
  localparam int WDOG_EN_BIT = 2;
  localparam int FOSC_LSB = 0;
  localparam logic [1:0] OSC_RC = 2'h3;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  // oscillator start-up delay
  localparam int OST_TOSC      = 1024;
  localparam int OSC_PERIOD_NS = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OST_CYC = (OST_TOSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int OST_W   = 11;

  typedef enum logic [1:0] {
    SWC_RUN    = 2'h0,
    SWC_SLEEP  = 2'h1,
    SWC_OST    = 2'h3,
    SWC_RESUME = 2'h2
  } swc_state_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } swc_bus_t;

  typedef struct packed {
    logic ex;
    logic pc;
    logic ee;
    logic tm;
  } swc_irq_t;

  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } swc_sync_st_t;

  typedef struct packed {
    logic       tick_d;
    logic [6:0] pre;
    logic [7:0] cnt;
    logic       to;
  } swc_wdt_st_t;

  typedef struct packed {
    swc_state_t        state;
    logic              pwrdn;
    logic              to;
    logic [7:0]        option;
    logic [7:0]        irqctl;
    logic [7:0]        cfg;
    logic              cfg_ok;
    logic [OST_W-1:0]  ost_cnt;
    logic              wake_irq;
    logic [PC_W-1:0]   wake_pc;
    logic [7:0]        rdata;
    logic              core_clk_en;
    logic              osc_en;
    logic              core_rst;
    logic              fetch_req;
    logic [PC_W-1:0]   fetch_addr;
    logic              vec_req;
    logic              wdt_clr;
    logic [IO_W-1:0]   io_out;
    logic [IO_W-1:0]   io_oe;
    logic              rstpin_oe;
  } swc_st_t;
endpackage
`default_nettype wire

// ==== swc_sync.sv ====
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module swc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output var  logic q
);
  swc_pkg::swc_sync_st_t r;
  swc_pkg::swc_sync_st_t n;

  always_comb begin
    n    = r;
    n.sh = {r.sh[1:0], d};
    if (r.sh[1] == r.sh[2]) begin
      n.q = r.sh[2];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= {{3{RST_VAL}}, RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule
`default_nettype wire

// ==== swc_wdt.sv ====
// watchdog counter on ticks of its own oscillator, optional postscaler
`timescale 1ns/10ps
`default_nettype none
module swc_wdt #(
  parameter int BASE_TICKS = 256
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       clr,
  input  wire logic       use_post,
  input  wire logic [2:0] ps,
  output var  logic       timeout
);
  if (BASE_TICKS < 2 || BASE_TICKS > 256) begin : g_bad_ticks
    $error("BASE_TICKS out of range");
  end
  localparam logic [7:0] LAST = 8'(BASE_TICKS - 1);

  swc_pkg::swc_wdt_st_t r;
  swc_pkg::swc_wdt_st_t n;
  logic [6:0] pre_last;

  always_comb begin
    n        = r;
    pre_last = use_post ? 7'((8'h01 << ps) - 8'h01) : 7'h00;
    n.tick_d = tick;
    n.to     = 1'b0;
    if (clr || !enable) begin
      n.pre = 7'h00;
      n.cnt = 8'h00;
    end else if (tick && !r.tick_d) begin
      if (r.cnt == LAST) begin
        n.cnt = 8'h00;
        if (r.pre == pre_last) begin
          n.pre = 7'h00;
          n.to  = 1'b1;
        end else begin
          n.pre = r.pre + 7'h01;
        end
      end else begin
        n.cnt = r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign timeout = r.to;
endmodule
`default_nettype wire

// ==== swc_core_model.sv ====
// behavioural core, port logic and watchdog oscillator facing the controller
`timescale 1ns/10ps
`default_nettype none
module swc_core_model (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     go,
  input  wire logic [swc_pkg::PC_W-1:0] pc,
  output var  logic                     sleep_instr,
  output var  logic                     watchdog_clear_instr,
  output var  logic [swc_pkg::PC_W-1:0] next_pc,
  output var  logic [swc_pkg::IO_W-1:0] io_out_in,
  output var  logic [swc_pkg::IO_W-1:0] io_oe_in,
  output var  logic                     wdt_osc
);
  logic [2:0] osc_cnt_r;
  // watchdog rc oscillator runs free, one period every eight clocks
  assign wdt_osc = osc_cnt_r[2];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt_r            <= 3'h0;
      watchdog_clear_instr <= 1'b0;
      sleep_instr          <= 1'b0;
      next_pc              <= 13'h0000;
      io_out_in            <= 13'h0AAA;
      io_oe_in             <= 13'h0000;
    end else begin
      osc_cnt_r            <= osc_cnt_r + 3'h1;
      watchdog_clear_instr <= go;
      sleep_instr          <= watchdog_clear_instr;
      if (go) begin
        // the word after sleep is a no-op, so a wake may run it
        next_pc <= pc + 13'h0001;
      end
      // port drive changes every cycle so a leak through sleep shows
      io_out_in <= ~io_out_in;
      io_oe_in  <= io_oe_in + 13'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the sleep/wake controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              clk;
  logic              rst_b;
  swc_pkg::swc_bus_t bus;
  logic [7:0]        rdata;
  logic              rstpin_b;
  logic              master_clear_oe;
  logic              wdt_osc;
  logic [7:0]        cfg_strap;
  logic              sleep_instr;
  logic              wci;
  logic [12:0]       next_pc;
  swc_pkg::swc_irq_t irq_flags;
  logic [12:0]       io_out_in;
  logic [12:0]       io_oe_in;
  logic [12:0]       io_out;
  logic [12:0]       io_oe;
  logic              osc_drive_en;
  logic              core_clk_en;
  logic              core_reset;
  logic              fetch_req;
  logic [12:0]       fetch_addr;
  logic              vector_req;
  logic [12:0]       vector_addr;
  logic              asleep;
  logic              wdt_cleared;
  logic              sleep_clr;
  logic              go;
  logic [12:0]       pc;
  logic              rst_seen;
  int                num_errors;
  int                comparisons;
  int                cycles;

  swc_top #(.WDT_TICKS(4)) swc_top_inst (
    .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .master_clear_pin_b(rstpin_b), .master_clear_oe(master_clear_oe),
    .wdt_osc(wdt_osc), .cfg_strap(cfg_strap), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(wci), .next_pc(next_pc), .irq_flags(irq_flags),
    .io_out_in(io_out_in), .io_oe_in(io_oe_in), .io_out(io_out),
    .io_oe(io_oe), .osc_drive_en(osc_drive_en), .core_clk_en(core_clk_en),
    .core_reset(core_reset), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .vector_req(vector_req),
    .vector_addr(vector_addr), .wdt_cleared(wdt_cleared), .asleep(asleep));

  swc_core_model swc_core_model_inst (
    .clk(clk), .rst_b(rst_b), .go(go), .pc(pc), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(wci), .next_pc(next_pc), .io_out_in(io_out_in),
    .io_oe_in(io_oe_in), .wdt_osc(wdt_osc));

  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [13:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(rdata, e);
  endtask

  task automatic do_reset(input logic [7:0] cfg);
    @(posedge clk);
    cfg_strap <= cfg;
    rst_b     <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    step(2);
  endtask

  task automatic do_sleep(input logic [12:0] a);
    @(posedge clk);
    go <= 1'b1;
    pc <= a;
    @(posedge clk);
    go <= 1'b0;
    step(2);
    sleep_clr = wdt_cleared;
    step(2);
  endtask

  task automatic wait_fetch(input int mx, output int n);
    n = 0;
    while (fetch_req !== 1'b1 && n < mx) begin
      step(1);
      n++;
    end
  endtask

  task automatic reg_test;
    do_reset(8'h00);
    rd_chk(swc_pkg::STATUS_ADDR, 8'h18);
    rd_chk(swc_pkg::OPTION_ADDR, 8'hFF);
    rd_chk(swc_pkg::IRQCTL_ADDR, 8'h00);
    rd_chk(14'h0050, 8'h00);
    wr(swc_pkg::STATUS_ADDR, 8'h00);
    rd_chk(swc_pkg::STATUS_ADDR, 8'h18);
    wr(swc_pkg::OPTION_ADDR, 8'h5A);
    rd_chk(swc_pkg::OPTION_ADDR, 8'h5A);
  endtask

  task automatic noop_test;
    wr(swc_pkg::IRQCTL_ADDR, 8'h10);
    @(posedge clk);
    irq_flags <= 4'h8;
    do_sleep(13'h0100);
    chk({asleep, osc_drive_en}, 2'h1);
    chk(sleep_clr, 1'b0);
    rd_chk(swc_pkg::STATUS_ADDR, 8'h18);
    @(posedge clk);
    irq_flags <= 4'h0;
  endtask

  task automatic wake_test(input logic [7:0] cfg, input int src,
                           input int en, input logic g);
    logic [25:0] io_s;
    logic [7:0]  ie;
    int          n;
    do_reset(cfg);
    ie = 8'h20;
    ie[en] = 1'b1;
    ie[7] = g;
    wr(swc_pkg::IRQCTL_ADDR, ie);
    rst_seen = 1'b0;
    do_sleep(13'h0A50);
    chk({asleep, osc_drive_en, core_clk_en}, 3'h4);
    chk(sleep_clr, 1'b1);
    rd_chk(swc_pkg::STATUS_ADDR, 8'h10);
    io_s = {io_out, io_oe};
    @(posedge clk);
    irq_flags <= 4'hF & ~(4'h1 << src);
    step(20);
    chk(asleep, 1'b1);
    chk({io_out, io_oe}, io_s);
    @(posedge clk);
    irq_flags <= 4'hF;
    wait_fetch(1200, n);
    if (cfg[1:0] == swc_pkg::OSC_RC) begin
      chk(n < 8, 1'b1);
    end else begin
      chk(n >= swc_pkg::OST_CYC && n < swc_pkg::OST_CYC + 8, 1'b1);
    end
    chk({core_clk_en, fetch_addr}, {1'b1, 13'h0A51});
    chk({vector_req, vector_addr}, {g, swc_pkg::VECTOR_ADDR});
    chk(rst_seen, 1'b0);
    @(posedge clk);
    irq_flags <= 4'h0;
  endtask

  task automatic rstpin_test;
    int n;
    do_reset(8'h00);
    wr(swc_pkg::IRQCTL_ADDR, 8'h90);
    do_sleep(13'h0300);
    @(posedge clk);
    rstpin_b <= 1'b0;
    step(8);
    chk(core_reset, 1'b1);
    @(posedge clk);
    rstpin_b <= 1'b1;
    wait_fetch(1200, n);
    chk(n >= swc_pkg::OST_CYC - 8 && n <= swc_pkg::OST_CYC, 1'b1);
    chk(fetch_addr, 13'h0000);
    rd_chk(swc_pkg::IRQCTL_ADDR, 8'h00);
    rd_chk(swc_pkg::STATUS_ADDR, 8'h10);
  endtask

  task automatic wdt_test;
    int n;
    do_reset(8'h04);
    wr(swc_pkg::OPTION_ADDR, 8'h0F);
    rst_seen = 1'b0;
    do_sleep(13'h0200);
    chk(asleep, 1'b1);
    wait_fetch(7000, n);
    chk({rst_seen, fetch_addr}, {1'b0, 13'h0201});
    rd_chk(swc_pkg::STATUS_ADDR, 8'h00);
    n = 0;
    while (core_reset !== 1'b1 && n < 6000) begin
      step(1);
      n++;
    end
    chk(core_reset, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the master clear pin is never driven, whatever resets the core
  always @(negedge clk) begin
    if (rst_b === 1'b1) begin
      chk(master_clear_oe, 1'b0);
    end
  end

  always @(posedge clk) begin
    if (core_reset === 1'b1) begin
      rst_seen <= 1'b1;
    end
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  initial begin
    num_errors  = 0;
    comparisons = 0;
    cycles      = 0;
    rst_b       = 1'b0;
    bus         = '0;
    rstpin_b    = 1'b1;
    cfg_strap   = 8'h00;
    irq_flags   = 4'h0;
    go          = 1'b0;
    pc          = 13'h0000;
    rst_seen    = 1'b0;
    reg_test();
    noop_test();
    wake_test(8'h00, 3, 4, 1'b0);
    wake_test(8'h01, 2, 3, 1'b1);
    wake_test(8'h02, 3, 4, 1'b1);
    wake_test(8'h03, 1, 6, 1'b0);
    rstpin_test();
    wdt_test();
    tally_and_finish();
  end
endmodule
`default_nettype wire
